//--- logic/cab_pkg.sv
package cab_pkg;

   // Status flag bit positions
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 1;
   localparam int FLAG_N = 2;
   localparam int FLAG_V = 3;
   localparam int FLAG_S = 4;
   localparam int FLAG_H = 5;
   localparam int FLAG_T = 6;
   localparam int FLAG_I = 7;
   localparam logic [7:0] FLAGS_RST = 8'h00;

   // Widths
   localparam int PC_W = 22;
   localparam int OFS_W = 12;
   localparam int WK_W = 6;
   localparam int PTR_W = 16;

   // Cycle counts and program-counter steps
   localparam logic [1:0] CYC_NONE = 2'h0;
   localparam logic [1:0] CYC_ONE = 2'h1;
   localparam logic [1:0] CYC_TWO = 2'h2;
   localparam logic [1:0] CYC_THREE = 2'h3;
   localparam logic [PC_W-1:0] PC_STEP = 22'h000001;
   localparam logic [PC_W-1:0] PC_SKIP_SHORT = 22'h000002;
   localparam logic [PC_W-1:0] PC_SKIP_LONG = 22'h000003;
   localparam logic [PC_W-PTR_W-1:0] PC_HIGH_CLR = 6'h00;

   typedef enum logic [5:0] {
      OP_ADD, OP_ADD_CARRY, OP_SUB, OP_SUB_WITH_BORROW, OP_SUB_IMM_WITH_BORROW,
      OP_COMPARE, OP_COMPARE_CARRY, OP_AND, OP_OR, OP_XOR, OP_ONES_COMP, OP_NEGATE,
      OP_INCREMENT, OP_DECREMENT, OP_WORD_ADD_IMMEDIATE, OP_WORD_SUB_IMMEDIATE,
      OP_MULTIPLY, OP_SIGNED_MULTIPLY, OP_MIXED_SIGN_MULTIPLY, OP_FRACTIONAL_MULTIPLY,
      OP_FRACTIONAL_SIGNED, OP_FRACTIONAL_MIXED, OP_BRANCH_FLAG_SET, OP_BRANCH_FLAG_CLEAR,
      OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_LT, OP_BRANCH_HALF_CARRY_SET,
      OP_COMPARE_SKIP_EQUAL, OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET,
      OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET, OP_POINTER_JUMP, OP_POINTER_CALL
   } cab_op_t;

   // Operation request from the decoder
   typedef struct packed {
      cab_op_t op;
      logic [7:0] opA;
      logic [7:0] opB;
      logic [15:0] pair;
      logic [WK_W-1:0] wordK;
      logic [OFS_W-1:0] ofs;
      logic [PC_W-1:0] pc;
      logic [PTR_W-1:0] zPtr;
      logic [2:0] bitSel;
      logic ioBit;
      logic nextLong;
   } cab_req_t;

   // Completion record, valid for the one cycle that done is high
   typedef struct packed {
      logic done;
      logic wrByte;
      logic wrPair;
      logic toR1R0;
      logic [15:0] result;
      logic pcLoad;
      logic [PC_W-1:0] pcNext;
      logic push;
      logic [PC_W-1:0] retAddr;
   } cab_rsp_t;

endpackage

//--- logic/cab_alu.sv
`timescale 1ns/100ps
module cab_alu (
   input wire cab_pkg::cab_op_t op, // Operation
   input wire logic [7:0] a, // Destination operand
   input wire logic [7:0] b, // Source or constant
   input wire logic [15:0] pair, // Register pair value
   input wire logic [cab_pkg::WK_W-1:0] wordK, // Word constant
   input wire logic [7:0] flagsIn, // Current flags
   output logic [15:0] res, // Result
   output logic [7:0] flagsOut, // Updated flags
   output logic wrByte, // Write back byte
   output logic wrPair, // Write back pair
   output logic isAlu // Operation handled here
);
   import cab_pkg::*;

   logic isSub, cIn, cEff, carry, half, ovf;
   logic [7:0] bEff, r8;
   logic [8:0] s9;
   logic [4:0] h5;
   logic [16:0] w17;

   // Shared byte adder; subtraction is a plus not-b plus not-borrow
   always_comb begin
      isSub = op inside {OP_SUB, OP_SUB_WITH_BORROW, OP_SUB_IMM_WITH_BORROW, OP_COMPARE,
                         OP_COMPARE_CARRY, OP_NEGATE, OP_DECREMENT};
      cIn = (op inside {OP_ADD_CARRY, OP_SUB_WITH_BORROW, OP_SUB_IMM_WITH_BORROW,
                        OP_COMPARE_CARRY}) && flagsIn[FLAG_C];
      bEff = (op inside {OP_INCREMENT, OP_DECREMENT}) ? 8'h01 : b;
      if (op == OP_NEGATE) begin
         bEff = a;
      end
      bEff = isSub ? ~bEff : bEff;
      cEff = isSub ? ~cIn : cIn;
      s9 = {1'b0, (op == OP_NEGATE) ? 8'h00 : a} + {1'b0, bEff} + {8'h00, cEff};
      h5 = {1'b0, (op == OP_NEGATE) ? 4'h0 : a[3:0]} + {1'b0, bEff[3:0]} + {4'h0, cEff};
      r8 = s9[7:0];
      carry = s9[8] ^ isSub;
      half = h5[4] ^ isSub;
      ovf = (((op == OP_NEGATE) ? 1'b0 : a[7]) == bEff[7]) && (r8[7] != bEff[7]);
      w17 = (op == OP_WORD_SUB_IMMEDIATE) ? {1'b0, pair} - {11'h000, wordK}
                                          : {1'b0, pair} + {11'h000, wordK};
   end

   // Result and flag selection
   always_comb begin
      res = {8'h00, r8};
      flagsOut = flagsIn;
      wrByte = 1'b1;
      wrPair = 1'b0;
      isAlu = 1'b1;
      case (op)
         OP_ADD, OP_ADD_CARRY, OP_SUB, OP_SUB_WITH_BORROW, OP_SUB_IMM_WITH_BORROW, OP_COMPARE,
         OP_COMPARE_CARRY, OP_NEGATE: begin
            flagsOut[FLAG_C] = carry;
            flagsOut[FLAG_H] = half;
            flagsOut[FLAG_V] = ovf;
            wrByte = !(op inside {OP_COMPARE, OP_COMPARE_CARRY});
         end
         OP_INCREMENT, OP_DECREMENT: flagsOut[FLAG_V] = ovf;
         OP_AND, OP_OR, OP_XOR: begin
            res = {8'h00, (op == OP_AND) ? (a & b) : (op == OP_OR) ? (a | b) : (a ^ b)};
            flagsOut[FLAG_V] = 1'b0;
         end
         OP_ONES_COMP: begin
            res = {8'h00, ~a};
            flagsOut[FLAG_V] = 1'b0;
            flagsOut[FLAG_C] = 1'b1;
         end
         OP_WORD_ADD_IMMEDIATE, OP_WORD_SUB_IMMEDIATE: begin
            res = w17[15:0];
            wrByte = 1'b0;
            wrPair = 1'b1;
            flagsOut[FLAG_C] = w17[16];
            flagsOut[FLAG_V] = (op == OP_WORD_SUB_IMMEDIATE) ? (pair[15] && !w17[15])
                                                             : (!pair[15] && w17[15]);
         end
         default: begin
            isAlu = 1'b0;
            wrByte = 1'b0;
         end
      endcase
      // Zero chains through the borrow-subtract and compare-with-carry forms so multi-byte results test whole
      if (wrPair) begin
         flagsOut[FLAG_Z] = (res == 16'h0000);
         flagsOut[FLAG_N] = res[15];
      end else if (isAlu) begin
         flagsOut[FLAG_Z] = (res[7:0] == 8'h00) &&
            (!(op inside {OP_SUB_WITH_BORROW, OP_SUB_IMM_WITH_BORROW, OP_COMPARE_CARRY})
             || flagsIn[FLAG_Z]);
         flagsOut[FLAG_N] = res[7];
      end
      if (isAlu) begin
         flagsOut[FLAG_S] = flagsOut[FLAG_N] ^ flagsOut[FLAG_V];
      end
   end
endmodule // cab_alu

//--- logic/cab_mul.sv
`timescale 1ns/100ps
module cab_mul (
   input wire logic [7:0] a, // Destination operand
   input wire logic [7:0] b, // Source operand
   input wire logic signA, // Treat a as signed
   input wire logic signB, // Treat b as signed
   input wire logic frac, // Fractional form
   output logic [15:0] prod, // Product for r1:r0
   output logic zf, // Zero flag
   output logic cf // Carry flag
);
   logic signed [8:0] xa, xb;
   logic signed [17:0] full;

   // Sign extension picks the operand form
   always_comb begin
      xa = {signA & a[7], a};
      xb = {signB & b[7], b};
      full = xa * xb;
      cf = full[15];
      prod = frac ? {full[14:0], 1'b0} : full[15:0];
      zf = (prod == 16'h0000);
   end
endmodule // cab_mul

//--- logic/cab_exec.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Subtract constant with borrow writes d-K-C, sets Z,C,N,V,S,H, one cycle.
// - Word add of constant to pair sets Z,C,N,V,S, not H, two cycles.
// - Word subtract of constant from pair sets Z,C,N,V,S, keeps H, two cycles.
// - Mixed multiply, signed d by unsigned r, product to r1:r0, Z and C, two cycles.
// - Signed greater-or-equal branch taken when N xor V is 0; PC+k+1; 1 or 2 cycles.
// - Signed less-than branch taken when N xor V is 1; same target and timing.
// - Compare-skip-equal skips next word(s) when equal; 1/2/3 cycles, no flags.
// - Pointer jump loads PC low 16 bits from Z, clears bits 21:16, two cycles.
// - Pointer call loads PC from Z, high bits zero, two or three cycles, no flags.
// - Half-carry-set branch taken only when H is one; PC+k+1; 1 or 2 cycles.
// - Skip-if-I/O-bit-clear skips next instruction when bit is zero; 1 to 3 cycles.
module cab_exec #(
   parameter logic [1:0] CALL_CYCLES = 2'h2 // Pointer call length, 2 or 3
) (
   input wire logic mclk, // Core clock
   input wire logic srst, // Synchronous reset
   input wire logic reqValid, // Operation strobe
   input wire cab_pkg::cab_req_t req, // Operation and operands
   output cab_pkg::cab_rsp_t rsp_q, // Completion record
   output logic [7:0] statusFlag_q, // Status flag register
   output logic busy_q // Multi-cycle operation running
);
   import cab_pkg::*;

   // Parameter check
   if (CALL_CYCLES != CYC_TWO && CALL_CYCLES != CYC_THREE) begin : gBadCallCycles
      $error("CALL_CYCLES must be 2 or 3");
   end

   logic take;
   logic commitNow;
   logic [1:0] cnt_q;
   logic [1:0] nxtCyc;
   cab_rsp_t nxtRsp;
   cab_rsp_t pendRsp_q;
   logic [7:0] nxtFlags;
   logic [7:0] pendFlags_q;

   logic [15:0] aluRes;
   logic [7:0] aluFlags;
   logic aluWrByte;
   logic aluWrPair;
   logic aluIsOp;

   logic [15:0] mulProd;
   logic mulZ;
   logic mulC;
   logic mulSignA;
   logic mulSignB;
   logic mulFrac;

   logic cond;
   logic [PC_W-1:0] pcSeq;
   logic [PC_W-1:0] pcBranch;
   logic [PC_W-1:0] pcSkip;

   // Multiply family check, used only to select the response
   function automatic logic isMul(input cab_op_t op);
      return op inside {OP_MULTIPLY, OP_SIGNED_MULTIPLY, OP_MIXED_SIGN_MULTIPLY,
                        OP_FRACTIONAL_MULTIPLY, OP_FRACTIONAL_SIGNED, OP_FRACTIONAL_MIXED};
   endfunction

   // Relative branch family
   function automatic logic isBranch(input cab_op_t op);
      return op inside {OP_BRANCH_FLAG_SET, OP_BRANCH_FLAG_CLEAR, OP_BRANCH_SIGNED_GE,
                        OP_BRANCH_SIGNED_LT, OP_BRANCH_HALF_CARRY_SET};
   endfunction

   // Skip family
   function automatic logic isSkip(input cab_op_t op);
      return op inside {OP_COMPARE_SKIP_EQUAL, OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET,
                        OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET};
   endfunction

   // Branch conditions against the live flags, skip conditions against the operands and I/O bit
   function automatic logic condMet(input cab_req_t r, input logic [7:0] f);
      logic c;
      c = 1'b0;
      case (r.op)
         OP_BRANCH_FLAG_SET: c = f[r.bitSel];
         OP_BRANCH_FLAG_CLEAR: c = !f[r.bitSel];
         OP_BRANCH_SIGNED_GE: c = ((f[FLAG_N] ^ f[FLAG_V]) == 1'b0);
         OP_BRANCH_SIGNED_LT: c = ((f[FLAG_N] ^ f[FLAG_V]) == 1'b1);
         OP_BRANCH_HALF_CARRY_SET: c = f[FLAG_H];
         OP_COMPARE_SKIP_EQUAL: c = (r.opA == r.opB);
         OP_SKIP_REG_BIT_CLEAR: c = !r.opA[r.bitSel];
         OP_SKIP_REG_BIT_SET: c = r.opA[r.bitSel];
         OP_SKIP_IO_BIT_CLEAR: c = !r.ioBit;
         OP_SKIP_IO_BIT_SET: c = r.ioBit;
         default: c = 1'b0;
      endcase
      return c;
   endfunction

   // Byte and word arithmetic and logic
   cab_alu uAlu (
      .op(req.op),
      .a(req.opA),
      .b(req.opB),
      .pair(req.pair),
      .wordK(req.wordK),
      .flagsIn(statusFlag_q),
      .res(aluRes),
      .flagsOut(aluFlags),
      .wrByte(aluWrByte),
      .wrPair(aluWrPair),
      .isAlu(aluIsOp)
   );

   // Multiplier operand forms
   always_comb begin
      mulSignA = req.op inside {OP_SIGNED_MULTIPLY, OP_MIXED_SIGN_MULTIPLY,
                                OP_FRACTIONAL_SIGNED, OP_FRACTIONAL_MIXED};
      mulSignB = req.op inside {OP_SIGNED_MULTIPLY, OP_FRACTIONAL_SIGNED};
      mulFrac = req.op inside {OP_FRACTIONAL_MULTIPLY, OP_FRACTIONAL_SIGNED,
                               OP_FRACTIONAL_MIXED};
   end

   cab_mul uMul (
      .a(req.opA),
      .b(req.opB),
      .signA(mulSignA),
      .signB(mulSignB),
      .frac(mulFrac),
      .prod(mulProd),
      .zf(mulZ),
      .cf(mulC)
   );

   // Program-counter candidates
   always_comb begin
      pcSeq = req.pc + PC_STEP;
      pcBranch = req.pc + {{(PC_W-OFS_W){req.ofs[OFS_W-1]}}, req.ofs} + PC_STEP;
      pcSkip = req.pc + (req.nextLong ? PC_SKIP_LONG : PC_SKIP_SHORT);
      cond = condMet(req, statusFlag_q);
   end

   // Response, new flags and cycle count for the offered operation
   always_comb begin
      nxtRsp = '0;
      nxtRsp.done = 1'b1;
      nxtFlags = statusFlag_q;
      nxtCyc = CYC_ONE;
      if (aluIsOp) begin
         nxtRsp.result = aluRes;
         nxtRsp.wrByte = aluWrByte;
         nxtRsp.wrPair = aluWrPair;
         nxtFlags = aluFlags;
         nxtCyc = aluWrPair ? CYC_TWO : CYC_ONE;
      end else if (isMul(req.op)) begin
         nxtRsp.result = mulProd;
         nxtRsp.wrPair = 1'b1;
         nxtRsp.toR1R0 = 1'b1;
         nxtFlags[FLAG_Z] = mulZ;
         nxtFlags[FLAG_C] = mulC;
         nxtCyc = CYC_TWO;
      end else if (isBranch(req.op)) begin
         nxtRsp.pcLoad = 1'b1;
         nxtRsp.pcNext = cond ? pcBranch : pcSeq;
         nxtCyc = cond ? CYC_TWO : CYC_ONE;
      end else if (isSkip(req.op)) begin
         nxtRsp.pcLoad = 1'b1;
         nxtRsp.pcNext = cond ? pcSkip : pcSeq;
         if (cond) begin
            nxtCyc = req.nextLong ? CYC_THREE : CYC_TWO;
         end
      end else if (req.op == OP_POINTER_JUMP) begin
         nxtRsp.pcLoad = 1'b1;
         nxtRsp.pcNext = {PC_HIGH_CLR, req.zPtr};
         nxtCyc = CYC_TWO;
      end else if (req.op == OP_POINTER_CALL) begin
         nxtRsp.pcLoad = 1'b1;
         nxtRsp.pcNext = {PC_HIGH_CLR, req.zPtr};
         nxtRsp.push = 1'b1;
         nxtRsp.retAddr = pcSeq;
         nxtCyc = CALL_CYCLES;
      end
   end

   // Accept only while idle; finish now for single-cycle work
   always_comb begin
      take = reqValid && !busy_q;
      commitNow = take && (nxtCyc == CYC_ONE);
   end

   // Remaining cycles of the running operation
   always_ff @(posedge mclk) begin
      if (srst) begin
         cnt_q <= CYC_NONE;
      end else if (take) begin
         cnt_q <= nxtCyc - CYC_ONE;
      end else if (cnt_q != CYC_NONE) begin
         cnt_q <= cnt_q - CYC_ONE;
      end
   end

   // Busy while a longer operation counts down
   always_ff @(posedge mclk) begin
      if (srst) begin
         busy_q <= 1'b0;
      end else if (take) begin
         busy_q <= (nxtCyc != CYC_ONE);
      end else if (cnt_q == CYC_ONE) begin
         busy_q <= 1'b0;
      end
   end

   // Held result of a longer operation
   always_ff @(posedge mclk) begin
      if (srst) begin
         pendRsp_q <= '0;
         pendFlags_q <= FLAGS_RST;
      end else if (take) begin
         pendRsp_q <= nxtRsp;
         pendFlags_q <= nxtFlags;
      end
   end

   // Completion record, high for one cycle at the end
   always_ff @(posedge mclk) begin
      if (srst) begin
         rsp_q <= '0;
      end else if (commitNow) begin
         rsp_q <= nxtRsp;
      end else if (busy_q && cnt_q == CYC_ONE) begin
         rsp_q <= pendRsp_q;
      end else begin
         rsp_q <= '0;
      end
   end

   // Flags change together with the completion
   always_ff @(posedge mclk) begin
      if (srst) begin
         statusFlag_q <= FLAGS_RST;
      end else if (commitNow) begin
         statusFlag_q <= nxtFlags;
      end else if (busy_q && cnt_q == CYC_ONE) begin
         statusFlag_q <= pendFlags_q;
      end
   end

endmodule // cab_exec

//--- verification/cab_exec_properties.sv
`timescale 1ns/100ps
module cab_exec_properties #(
   parameter logic [1:0] CALL_CYCLES = 2'h2 // Pointer call length
) (
   input wire logic mclk, // Core clock
   input wire logic srst, // Reset
   input wire logic reqValid, // Strobe
   input wire cab_pkg::cab_req_t req, // Request
   input wire cab_pkg::cab_rsp_t rsp_q, // Completion
   input wire logic [7:0] statusFlag_q, // Flags
   input wire logic busy_q // Busy
);
   import cab_pkg::*;
   cab_req_t rq;
   logic [7:0] fq;
   logic taken, nv, isBr, brGo;
   logic [15:0] mixProd, fracProd;
   logic [PC_W-1:0] brTgt;
   // Decode helpers
   assign taken = reqValid && !busy_q;
   assign nv = statusFlag_q[FLAG_N] ^ statusFlag_q[FLAG_V];
   assign isBr = req.op inside {OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_LT, OP_BRANCH_HALF_CARRY_SET};
   assign brGo = (req.op == OP_BRANCH_SIGNED_GE && !nv) || (req.op == OP_BRANCH_SIGNED_LT && nv)
      || (req.op == OP_BRANCH_HALF_CARRY_SET && statusFlag_q[FLAG_H]);
   assign mixProd = {{8{rq.opA[7]}}, rq.opA} * {8'h00, rq.opB};
   assign fracProd = ({8'h00, rq.opA} * {8'h00, rq.opB}) << 1;
   assign brTgt = rq.pc + {{10{rq.ofs[11]}}, rq.ofs} + PC_STEP;
   // Request and flags captured at the taking edge
   always_ff @(posedge mclk) begin
      if (taken) begin
         rq <= req;
         fq <= statusFlag_q;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   property p_sub_borrow;
      taken && req.op == OP_SUB_IMM_WITH_BORROW |=> rsp_q.done && rsp_q.wrByte
         && rsp_q.result[7:0] == rq.opA - rq.opB - fq[FLAG_C];
   endproperty
   a_sub_borrow: assert property (p_sub_borrow) else $error("borrow subtract wrong");
   property p_word;
      taken && req.op inside {OP_WORD_ADD_IMMEDIATE, OP_WORD_SUB_IMMEDIATE} |=> busy_q && !rsp_q.done ##1
         rsp_q.done && rsp_q.wrPair && statusFlag_q[FLAG_H] == fq[FLAG_H] && rsp_q.result ==
         (rq.op == OP_WORD_ADD_IMMEDIATE ? rq.pair + rq.wordK : rq.pair - rq.wordK);
   endproperty
   a_word: assert property (p_word) else $error("word operation wrong");
   property p_mul;
      taken && req.op inside {OP_MIXED_SIGN_MULTIPLY, OP_FRACTIONAL_MULTIPLY} |=> !rsp_q.done ##1 rsp_q.done
         && rsp_q.toR1R0 && statusFlag_q[7:2] == fq[7:2]
         && rsp_q.result == (rq.op == OP_MIXED_SIGN_MULTIPLY ? mixProd : fracProd);
   endproperty
   a_mul: assert property (p_mul) else $error("multiply wrong");
   property p_br_taken;
      taken && isBr && brGo |=> !rsp_q.done ##1 rsp_q.done && rsp_q.pcLoad && rsp_q.pcNext == brTgt;
   endproperty
   a_br_taken: assert property (p_br_taken) else $error("taken branch wrong");
   property p_br_not;
      taken && isBr && !brGo |=> rsp_q.done && rsp_q.pcNext == rq.pc + PC_STEP && statusFlag_q == fq;
   endproperty
   a_br_not: assert property (p_br_not) else $error("untaken branch wrong");
   property p_cmp_skip;
      taken && req.op == OP_COMPARE_SKIP_EQUAL && req.opA == req.opB && req.nextLong |=> !rsp_q.done [*2]
         ##1 rsp_q.done && rsp_q.pcNext == rq.pc + PC_SKIP_LONG && statusFlag_q == fq;
   endproperty
   a_cmp_skip: assert property (p_cmp_skip) else $error("compare skip wrong");
   property p_io_skip;
      taken && req.op == OP_SKIP_IO_BIT_CLEAR && !req.ioBit && !req.nextLong |=> !rsp_q.done ##1
         rsp_q.done && rsp_q.pcNext == rq.pc + PC_SKIP_SHORT;
   endproperty
   a_io_skip: assert property (p_io_skip) else $error("io skip wrong");
   property p_ptr_jump;
      taken && req.op == OP_POINTER_JUMP |=> !rsp_q.done ##1 rsp_q.done && rsp_q.pcNext == {PC_HIGH_CLR, rq.zPtr};
   endproperty
   a_ptr_jump: assert property (p_ptr_jump) else $error("pointer jump wrong");
   property p_ptr_call;
      taken && req.op == OP_POINTER_CALL |=> !rsp_q.done ##[1:2] rsp_q.done && rsp_q.push
         && rsp_q.pcNext == {PC_HIGH_CLR, rq.zPtr} && statusFlag_q == fq;
   endproperty
   a_ptr_call: assert property (p_ptr_call) else $error("pointer call wrong");
   property p_logic;
      taken && req.op inside {OP_AND, OP_OR, OP_XOR} |=> rsp_q.done && rsp_q.wrByte
         && statusFlag_q[FLAG_C] == fq[FLAG_C] && statusFlag_q[FLAG_H] == fq[FLAG_H] && !statusFlag_q[FLAG_V]
         && statusFlag_q[FLAG_Z] == (rsp_q.result[7:0] == 8'h00) && rsp_q.result[7:0] == (rq.op == OP_AND
         ? rq.opA & rq.opB : rq.op == OP_OR ? rq.opA | rq.opB : rq.opA ^ rq.opB);
   endproperty
   a_logic: assert property (p_logic) else $error("logic operation wrong");
   c_call: cover property (taken && req.op == OP_POINTER_CALL);
   c_br: cover property (taken && isBr && brGo);
   c_word: cover property (taken && req.op == OP_WORD_SUB_IMMEDIATE);
endmodule // cab_exec_properties
bind cab_exec cab_exec_properties #(.CALL_CYCLES(CALL_CYCLES)) i_cab_exec_properties (.mclk(mclk), .srst(srst),
   .reqValid(reqValid), .req(req), .rsp_q(rsp_q), .statusFlag_q(statusFlag_q), .busy_q(busy_q));

//--- verification/cab_seq_model.sv
`timescale 1ns/100ps
module cab_seq_model (
   input wire logic mclk, // Core clock
   input wire logic srst, // Reset
   input wire logic goIn, // Issue one instruction
   input wire cab_pkg::cab_req_t reqIn, // Instruction to issue
   input wire logic busy_q, // Design busy
   input wire cab_pkg::cab_rsp_t rsp_q, // Design completion
   output logic reqValid, // Request strobe
   output cab_pkg::cab_req_t req, // Request
   output logic pend, // Waiting for completion
   output cab_pkg::cab_rsp_t lastRsp, // Completion seen
   output logic [3:0] cycles // Cycles from take to done
);
   import cab_pkg::*;
   // Hold the strobe until taken
   always_ff @(posedge mclk) begin
      if (srst) reqValid <= 1'b0;
      else if (goIn) reqValid <= 1'b1;
      else if (!busy_q) reqValid <= 1'b0;
   end
   // Scramble the request once released
   always_ff @(posedge mclk) begin
      if (goIn) req <= reqIn;
      else if (reqValid && !busy_q) req <= ~req;
   end
   // Time the answer and keep it
   always_ff @(posedge mclk) begin
      if (srst) begin
         pend <= 1'b0;
         cycles <= 4'h0;
         lastRsp <= '0;
      end else if (goIn) pend <= 1'b1;
      else if (reqValid && !busy_q) cycles <= 4'h1;
      else if (pend && rsp_q.done) begin
         pend <= 1'b0;
         lastRsp <= rsp_q;
      end else if (pend) cycles <= cycles + 4'h1;
   end
endmodule // cab_seq_model

//--- verification/test_cpu_alu_and_branch_unit.sv
`timescale 1ns/100ps
module test_cpu_alu_and_branch_unit;
   import cab_pkg::*;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic goIn = 1'b0;
   logic reqValid, busy_q, pend;
   logic [3:0] cycles;
   logic [7:0] statusFlag_q;
   cab_req_t req;
   cab_req_t rq = '0;
   cab_rsp_t rsp_q, lastRsp;
   int fails = 0;
   int total_checks = 0;
   int ticks = 0;
   // Core and its issuing sequencer
   cab_exec #(.CALL_CYCLES(2'h3)) i_cab_exec (.mclk(mclk), .srst(srst), .reqValid(reqValid), .req(req),
      .rsp_q(rsp_q), .statusFlag_q(statusFlag_q), .busy_q(busy_q));
   cab_seq_model i_cab_seq_model (.mclk(mclk), .srst(srst), .goIn(goIn), .reqIn(rq), .busy_q(busy_q),
      .rsp_q(rsp_q), .reqValid(reqValid), .req(req), .pend(pend), .lastRsp(lastRsp), .cycles(cycles));
   // Clock and hang guard
   initial forever #12.5 mclk = ~mclk;
   always @(posedge mclk) begin
      ticks++;
      if (ticks == 3000) begin
         fails++;
         close_out();
      end
   end
   task automatic close_out();
      if (fails == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   // Issue one instruction, wait for it, check its length
   task automatic run(input cab_op_t op, input logic [7:0] a, input logic [7:0] b, input logic [15:0] p,
      input logic [3:0] n);
      int k;
      rq.op = op;
      rq.opA = a;
      rq.opB = b;
      rq.pair = p;
      rq.wordK = b[5:0];
      @(posedge mclk);
      #1 goIn = 1'b1;
      @(posedge mclk);
      #1 goIn = 1'b0;
      k = 0;
      while (pend === 1'b1 && k < 20) begin
         @(posedge mclk);
         #1 k++;
      end
      check(32'(cycles), 32'(n));
   endtask
   task automatic chk(input logic [15:0] res, input logic [15:0] exp, input logic [7:0] fl);
      check(32'(res), 32'(exp));
      check(32'(statusFlag_q), 32'(fl));
   endtask
   task automatic run_pc(input cab_op_t op, input logic [PC_W-1:0] expPc, input logic [3:0] n);
      logic [7:0] fl;
      fl = statusFlag_q;
      run(op, rq.opA, rq.opB, rq.pair, n);
      check(32'(lastRsp.pcNext), 32'(expPc));
      check(32'(statusFlag_q), 32'(fl));
   endtask
   task automatic t_arith();
      run(OP_SUB_IMM_WITH_BORROW, 8'h10, 8'h01, 16'h0000, 4'h1);
      chk({8'h00, lastRsp.result[7:0]}, 16'h000F, 8'h20);
      run(OP_WORD_ADD_IMMEDIATE, 8'h00, 8'h01, 16'hFFFF, 4'h2);
      chk(lastRsp.result, 16'h0000, 8'h23);
      run(OP_WORD_SUB_IMMEDIATE, 8'h00, 8'h01, 16'h0000, 4'h2);
      chk(lastRsp.result, 16'hFFFF, 8'h35);
      run(OP_SUB_IMM_WITH_BORROW, 8'h05, 8'h04, 16'h0000, 4'h1);
      chk({8'h00, lastRsp.result[7:0]}, 16'h0000, 8'h00);
   endtask
   task automatic t_mul_logic();
      cab_op_t lops [3] = '{OP_AND, OP_OR, OP_XOR};
      logic [15:0] lres [3] = '{16'h0000, 16'h00FF, 16'h00FF};
      logic [7:0] lfl [3] = '{8'h03, 8'h15, 8'h15};
      run(OP_MIXED_SIGN_MULTIPLY, 8'hFF, 8'h02, 16'h0000, 4'h2);
      chk(lastRsp.result, 16'hFFFE, 8'h01);
      check(32'(lastRsp.toR1R0), 32'h1);
      for (int i = 0; i < 3; i++) begin
         run(lops[i], 8'hF0, 8'h0F, 16'h0000, 4'h1);
         chk({8'h00, lastRsp.result[7:0]}, lres[i], lfl[i]);
      end
      run(OP_FRACTIONAL_MULTIPLY, 8'h80, 8'h80, 16'h0000, 4'h2);
      chk(lastRsp.result, 16'h8000, 8'h14);
      run(OP_FRACTIONAL_SIGNED, 8'hC0, 8'h40, 16'h0000, 4'h2);
      chk(lastRsp.result, 16'hE000, 8'h15);
      run(OP_FRACTIONAL_MIXED, 8'h80, 8'h80, 16'h0000, 4'h2);
      chk(lastRsp.result, 16'h8000, 8'h15);
   endtask
   task automatic t_branch();
      rq.pc = 22'h000100;
      rq.ofs = 12'hFFE;
      run_pc(OP_BRANCH_SIGNED_GE, 22'h000101, 4'h1);
      run_pc(OP_BRANCH_SIGNED_LT, 22'h0000FF, 4'h2);
      run_pc(OP_BRANCH_HALF_CARRY_SET, 22'h000101, 4'h1);
      run(OP_SUB_IMM_WITH_BORROW, 8'h10, 8'h01, 16'h0000, 4'h1);
      run_pc(OP_BRANCH_SIGNED_GE, 22'h0000FF, 4'h2);
      run_pc(OP_BRANCH_SIGNED_LT, 22'h000101, 4'h1);
      run_pc(OP_BRANCH_HALF_CARRY_SET, 22'h0000FF, 4'h2);
   endtask
   task automatic t_skip_ptr();
      rq.pc = 22'h3F0000;
      rq.opA = 8'h33;
      rq.opB = 8'h33;
      rq.nextLong = 1'b1;
      rq.ioBit = 1'b0;
      rq.zPtr = 16'hBEEF;
      run_pc(OP_COMPARE_SKIP_EQUAL, 22'h3F0003, 4'h3);
      rq.opB = 8'h34;
      run_pc(OP_COMPARE_SKIP_EQUAL, 22'h3F0001, 4'h1);
      rq.nextLong = 1'b0;
      run_pc(OP_SKIP_IO_BIT_CLEAR, 22'h3F0002, 4'h2);
      rq.ioBit = 1'b1;
      run_pc(OP_SKIP_IO_BIT_CLEAR, 22'h3F0001, 4'h1);
      run_pc(OP_POINTER_JUMP, 22'h00BEEF, 4'h2);
      run_pc(OP_POINTER_CALL, 22'h00BEEF, 4'h3);
      check(32'(lastRsp.push), 32'h1);
      check(32'(lastRsp.retAddr), 32'h003F0001);
   endtask
   // Main sequence
   initial begin
      repeat (16) @(posedge mclk);
      #1 srst = 1'b0;
      t_arith();
      t_mul_logic();
      t_branch();
      t_skip_ptr();
      close_out();
   end
endmodule // test_cpu_alu_and_branch_unit
